// ---- tes_pkg.sv ----
package tes_pkg;

	// Field widths
	localparam int PTR_W = 64;
	localparam int LEN_W = 17;
	localparam int ACC_W = 24;
	localparam int CODE_W = 8;

	// Completion codes carried in events
	localparam logic [CODE_W-1:0] CC_NONE = 8'h00;
	localparam logic [CODE_W-1:0] CC_SUCCESS = 8'h01;
	localparam logic [CODE_W-1:0] CC_STALL = 8'h06;
	localparam logic [CODE_W-1:0] CC_SHORT = 8'h0D;

	// Reset values
	localparam logic [ACC_W-1:0] ACC_RESET = 24'h000000;
	localparam logic [LEN_W-1:0] LEN_ZERO = 17'h00000;

	// Kind of ring entry being retired
	typedef enum logic [1:0] {
		TRB_NORMAL,
		TRB_SETUP,
		TRB_EVDATA,
		TRB_LINK
	} tes_trb_kind_t;

	// Endpoint context state
	typedef enum logic [1:0] {
		EP_STOPPED,
		EP_RUNNING,
		EP_HALTED
	} tes_endpoint_state_field_t;

	// One retired ring entry with its bus outcome
	typedef struct packed {
		logic [PTR_W-1:0] ptr;
		tes_trb_kind_t kind;
		logic completion_interrupt_flag;
		logic short_packet_interrupt_flag;
		logic last;
		logic [LEN_W-1:0] len;
		logic [LEN_W-1:0] residue;
		logic short_pkt;
		logic [CODE_W-1:0] err_code;
		logic stall;
	} tes_trb_t;

	// Transfer event handed to the event ring
	typedef struct packed {
		logic [PTR_W-1:0] ptr;
		logic [CODE_W-1:0] code;
		logic [ACC_W-1:0] len;
		logic ed;
	} tes_event_t;

endpackage : tes_pkg

// ---- tes_event_data_length_accumulator.sv ----
`timescale 1ns/1ns
`default_nettype none

// Running byte count between event data entries
module tes_event_data_length_accumulator
	import tes_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic add_en,
	input wire logic [LEN_W-1:0] add_val,
	input wire logic clear,
	output logic [ACC_W-1:0] acc
);

	logic [ACC_W-1:0] acc_r;
	logic [ACC_W-1:0] acc_nxt;

	// Clear takes priority; report happens from the old value
	always_comb
	begin
		acc_nxt = acc_r;
		if (clear)
			acc_nxt = ACC_RESET;
		else if (add_en)
			acc_nxt = acc_r + ACC_W'(add_val);
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			acc_r <= ACC_RESET;
		else
			acc_r <= acc_nxt;
	end

	assign acc = acc_r;

	a_acc_cleared: assert property (@(posedge clk) disable iff (rst)
		clear |=> acc_r == ACC_RESET)
		else $error("accumulator not cleared after report");

endmodule : tes_event_data_length_accumulator
`default_nettype wire

// ---- tes_ep_fsm.sv ----
`timescale 1ns/1ns
`default_nettype none

// Endpoint context state: halt, reset to stopped, doorbell to running
module tes_ep_fsm
	import tes_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic err_halt,
	input wire logic isoch,
	input wire logic reset_ep_ok,
	input wire logic doorbell,
	output tes_endpoint_state_field_t state
);

	tes_endpoint_state_field_t state_r;
	tes_endpoint_state_field_t state_nxt;

	// Next state
	always_comb
	begin
		state_nxt = state_r;
		unique case (state_r)
			EP_RUNNING:
				if (err_halt && !isoch)
					state_nxt = EP_HALTED;
			EP_HALTED:
				if (reset_ep_ok)
					state_nxt = EP_STOPPED;
			EP_STOPPED:
				if (doorbell)
					state_nxt = EP_RUNNING;
			// Unused code falls back to a safe idle state
			default:
				state_nxt = EP_STOPPED;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			state_r <= EP_STOPPED;
		else
			state_r <= state_nxt;
	end

	assign state = state_r;

	sequence s_halted_then_reset;
		state_r == EP_HALTED ##0 reset_ep_ok;
	endsequence

	a_halt_on_err: assert property (@(posedge clk) disable iff (rst)
		state_r == EP_RUNNING && err_halt && !isoch |=> state_r == EP_HALTED)
		else $error("endpoint did not halt on error");

	a_isoch_no_halt: assert property (@(posedge clk) disable iff (rst)
		state_r == EP_RUNNING && isoch |=> state_r != EP_HALTED)
		else $error("isochronous endpoint halted");

	a_reset_stopped: assert property (@(posedge clk) disable iff (rst)
		s_halted_then_reset |=> state_r == EP_STOPPED ##1 state_r != EP_HALTED)
		else $error("reset endpoint did not reach stopped");

	a_doorbell_run: assert property (@(posedge clk) disable iff (rst)
		state_r == EP_STOPPED && doorbell |=> state_r == EP_RUNNING)
		else $error("doorbell did not restart endpoint");

endmodule : tes_ep_fsm
`default_nettype wire

// ---- tes_event_gen.sv ----
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// - Short packet gives Short Packet event at that entry, length is residue.
// - No short packet: last entry gives Success event, length zero.
// - Short on flag-only entry: event there, then again at last completion entry.
// - Successful TD with completion flag gives Success event with length zero.
// - Any error forces an event with error code and bytes moved.
// - Early events are Success; data entries report length zero.
// - Early event data entries report accumulator, then clear it.
// - Later completion-flagged entries repeat the completion code and length.
// - Later event data entries report only when parse-all flag is set.
// - Link entry with completion flag reports Success and count zero.
// - Transfer errors halt a non-isochronous endpoint until recovered.
// - Isochronous endpoints never halt; processing moves to next interval.
// - The controller never sends a STALL handshake itself.
// - Received STALL unschedules the ring, halts endpoint, reports Stall Error.
// - STALL answering SETUP reports Stall Error on setup entry and halts.
// - Successful reset endpoint command moves Halted to Stopped, ring stays off until a doorbell.
// - First doorbell in Stopped moves endpoint to Running.
module tes_event_gen
	import tes_pkg::*;
(
	input wire logic REF_CLK,
	input wire logic RESET,
	input wire logic TRB_VALID,
	output logic TRB_READY,
	input wire tes_trb_t TRB_IN,
	input wire logic ISOCH,
	input wire logic PARSE_ALL_EVENT_DATA_FLAG,
	input wire logic RESET_EP_OK,
	input wire logic DOORBELL,
	output logic EVENT_VALID,
	input wire logic EVENT_READY,
	output tes_event_t EVENT_OUT,
	output tes_endpoint_state_field_t ENDPOINT_STATE_FIELD,
	output logic SCHEDULED,
	output logic STALL_HANDSHAKE_EN
);

	tes_endpoint_state_field_t endpoint_state_field;
	logic [ACC_W-1:0] acc;
	logic take;
	logic after_r;
	logic after_nxt;
	logic [CODE_W-1:0] cc_r;
	logic [CODE_W-1:0] cc_nxt;
	logic [ACC_W-1:0] clen_r;
	logic [ACC_W-1:0] clen_nxt;
	logic ev_valid_r;
	logic ev_valid_nxt;
	tes_event_t ev_r;
	tes_event_t ev_nxt;
	logic ev_load;
	logic ev_load_r;
	logic acc_add;
	logic acc_clear;
	logic err_halt;
	logic [LEN_W-1:0] moved;
	logic has_err;

	// Entry accepted only while running and the event slot can take a new one
	assign TRB_READY = (endpoint_state_field == EP_RUNNING) && (!ev_valid_r || EVENT_READY);
	assign take = TRB_VALID && TRB_READY;
	assign moved = TRB_IN.len - TRB_IN.residue;
	assign has_err = TRB_IN.stall || (TRB_IN.err_code != CC_NONE);

	// Event decision per retired entry
	always_comb
	begin
		after_nxt = after_r;
		cc_nxt = cc_r;
		clen_nxt = clen_r;
		ev_load = 1'b0;
		ev_nxt = ev_r;
		ev_nxt.ptr = TRB_IN.ptr;
		acc_add = 1'b0;
		acc_clear = 1'b0;
		err_halt = 1'b0;
		if (take)
		begin
			if (after_r)
			begin
				// Advancing to TD end after the completion event
				if (TRB_IN.kind == TRB_LINK)
				begin
					ev_load = TRB_IN.completion_interrupt_flag;
					ev_nxt.code = CC_SUCCESS;
					ev_nxt.len = ACC_RESET;
					ev_nxt.ed = 1'b0;
				end
				else if (TRB_IN.kind == TRB_EVDATA)
				begin
					ev_load = TRB_IN.completion_interrupt_flag && PARSE_ALL_EVENT_DATA_FLAG;
					ev_nxt.code = cc_r;
					ev_nxt.len = acc;
					ev_nxt.ed = 1'b1;
					acc_clear = ev_load;
				end
				else
				begin
					ev_load = TRB_IN.completion_interrupt_flag;
					ev_nxt.code = cc_r;
					ev_nxt.len = clen_r;
					ev_nxt.ed = 1'b0;
				end
				if (TRB_IN.last)
					after_nxt = 1'b0;
			end
			else if (has_err)
			begin
				// Errors force an event whatever the flags say
				ev_load = 1'b1;
				ev_nxt.code = TRB_IN.stall ? CC_STALL : TRB_IN.err_code;
				ev_nxt.len = ACC_W'(moved);
				ev_nxt.ed = 1'b0;
				err_halt = 1'b1;
				cc_nxt = ev_nxt.code;
				clen_nxt = ev_nxt.len;
				// Isoch skips the rest of the TD up to its last entry
				after_nxt = ISOCH && !TRB_IN.last;
				acc_clear = 1'b1;
			end
			else if (TRB_IN.kind == TRB_LINK)
			begin
				ev_load = TRB_IN.completion_interrupt_flag;
				ev_nxt.code = CC_SUCCESS;
				ev_nxt.len = ACC_RESET;
				ev_nxt.ed = 1'b0;
			end
			else if (TRB_IN.kind == TRB_EVDATA)
			begin
				ev_load = TRB_IN.completion_interrupt_flag;
				ev_nxt.code = CC_SUCCESS;
				ev_nxt.len = acc;
				ev_nxt.ed = 1'b1;
				acc_clear = 1'b1;
			end
			else if (TRB_IN.short_pkt)
			begin
				// Short packet ends data phase of the TD
				ev_load = TRB_IN.short_packet_interrupt_flag || TRB_IN.completion_interrupt_flag;
				ev_nxt.code = CC_SHORT;
				ev_nxt.len = ACC_W'(TRB_IN.residue);
				ev_nxt.ed = 1'b0;
				cc_nxt = CC_SHORT;
				clen_nxt = ACC_W'(TRB_IN.residue);
				after_nxt = !TRB_IN.last;
				acc_add = 1'b1;
			end
			else
			begin
				// Full transfer: residue is zero
				ev_load = TRB_IN.completion_interrupt_flag;
				ev_nxt.code = CC_SUCCESS;
				ev_nxt.len = ACC_RESET;
				ev_nxt.ed = 1'b0;
				acc_add = 1'b1;
				if (TRB_IN.completion_interrupt_flag)
				begin
					cc_nxt = CC_SUCCESS;
					clen_nxt = ACC_RESET;
				end
			end
			if (TRB_IN.last)
				acc_clear = 1'b1;
		end
	end

	// Single event slot drained in order
	always_comb
	begin
		ev_valid_nxt = ev_valid_r;
		if (ev_load)
			ev_valid_nxt = 1'b1;
		else if (EVENT_READY)
			ev_valid_nxt = 1'b0;
	end

	always_ff @(posedge REF_CLK)
	begin
		if (RESET)
		begin
			after_r <= 1'b0;
			cc_r <= CC_NONE;
			clen_r <= ACC_RESET;
			ev_valid_r <= 1'b0;
			ev_r <= '0;
			ev_load_r <= 1'b0;
		end
		else
		begin
			after_r <= after_nxt;
			cc_r <= cc_nxt;
			clen_r <= clen_nxt;
			ev_valid_r <= ev_valid_nxt;
			ev_r <= ev_load ? ev_nxt : ev_r;
			ev_load_r <= ev_load;
		end
	end

	tes_event_data_length_accumulator u_acc (
		.clk(REF_CLK),
		.rst(RESET),
		.add_en(acc_add),
		.add_val(moved),
		.clear(acc_clear),
		.acc(acc)
	);

	tes_ep_fsm u_ep (
		.clk(REF_CLK),
		.rst(RESET),
		.err_halt(err_halt),
		.isoch(ISOCH),
		.reset_ep_ok(RESET_EP_OK),
		.doorbell(DOORBELL),
		.state(endpoint_state_field)
	);

	// Outputs
	assign EVENT_VALID = ev_valid_r;
	assign EVENT_OUT = ev_r;
	assign ENDPOINT_STATE_FIELD = endpoint_state_field;
	assign SCHEDULED = (endpoint_state_field == EP_RUNNING);
	assign STALL_HANDSHAKE_EN = 1'b0;

	sequence s_take_clean;
		take && !after_r && !has_err && TRB_IN.kind == TRB_NORMAL;
	endsequence

	a_short_event: assert property (@(posedge REF_CLK) disable iff (RESET)
		s_take_clean ##0 TRB_IN.short_pkt && (TRB_IN.short_packet_interrupt_flag || TRB_IN.completion_interrupt_flag) |=>
		EVENT_VALID && EVENT_OUT.code == CC_SHORT
		&& EVENT_OUT.len == ACC_W'($past(TRB_IN.residue))
		&& EVENT_OUT.ptr == $past(TRB_IN.ptr))
		else $error("short packet event wrong");

	a_early_success: assert property (@(posedge REF_CLK) disable iff (RESET)
		s_take_clean ##0 !TRB_IN.short_pkt && TRB_IN.completion_interrupt_flag && !TRB_IN.last |=>
		ev_load_r && EVENT_OUT.code == CC_SUCCESS
		&& EVENT_OUT.len == ACC_RESET && !EVENT_OUT.ed)
		else $error("early event not success with zero length");

	// Early event data entry reports and empties the accumulator
	sequence s_take_early_evdata;
		take && !after_r && !has_err && TRB_IN.kind == TRB_EVDATA && TRB_IN.completion_interrupt_flag;
	endsequence

	a_evdata_report: assert property (@(posedge REF_CLK) disable iff (RESET)
		s_take_early_evdata |=> ev_load_r && EVENT_OUT.code == CC_SUCCESS
		&& EVENT_OUT.len == $past(acc) && EVENT_OUT.ed && acc == ACC_RESET)
		else $error("event data report or accumulator clear wrong");

	a_not_running_refuse: assert property (@(posedge REF_CLK) disable iff (RESET)
		endpoint_state_field != EP_RUNNING |-> !TRB_READY)
		else $error("entry accepted while endpoint not running");

	a_isoch_sched: assert property (@(posedge REF_CLK) disable iff (RESET)
		take && has_err && ISOCH |=> SCHEDULED)
		else $error("isochronous endpoint left the schedule on error");

	a_final_success: assert property (@(posedge REF_CLK) disable iff (RESET)
		s_take_clean ##0 !TRB_IN.short_pkt && TRB_IN.completion_interrupt_flag && TRB_IN.last |=>
		EVENT_VALID && EVENT_OUT.code == CC_SUCCESS && EVENT_OUT.len == ACC_RESET
		&& EVENT_OUT.ptr == $past(TRB_IN.ptr))
		else $error("final success event wrong");

	a_error_forced: assert property (@(posedge REF_CLK) disable iff (RESET)
		take && !after_r && has_err |=> ev_load_r && EVENT_OUT.code != CC_SUCCESS)
		else $error("error did not force an event");

	a_stall_code: assert property (@(posedge REF_CLK) disable iff (RESET)
		take && !after_r && TRB_IN.stall && !ISOCH |=>
		EVENT_OUT.code == CC_STALL && !SCHEDULED)
		else $error("stall not reported or ring still scheduled");

	a_link_zero: assert property (@(posedge REF_CLK) disable iff (RESET)
		take && !has_err && TRB_IN.kind == TRB_LINK && TRB_IN.completion_interrupt_flag |=>
		ev_load_r && EVENT_OUT.code == CC_SUCCESS && EVENT_OUT.len == ACC_RESET)
		else $error("link event wrong");

	a_pae_gate: assert property (@(posedge REF_CLK) disable iff (RESET)
		take && after_r && TRB_IN.kind == TRB_EVDATA && !PARSE_ALL_EVENT_DATA_FLAG |=>
		!ev_load_r)
		else $error("event data reported without parse-all");

	a_repeat_code: assert property (@(posedge REF_CLK) disable iff (RESET)
		take && after_r && TRB_IN.kind == TRB_NORMAL && TRB_IN.completion_interrupt_flag |=>
		ev_load_r && EVENT_OUT.code == $past(cc_r) && EVENT_OUT.len == $past(clen_r))
		else $error("later event does not repeat completion");

	a_no_stall_tx: assert property (@(posedge REF_CLK) disable iff (RESET)
		!STALL_HANDSHAKE_EN)
		else $error("controller drove a stall handshake");

	a_event_held: assert property (@(posedge REF_CLK) disable iff (RESET)
		EVENT_VALID && !EVENT_READY |=> EVENT_VALID && $stable(EVENT_OUT))
		else $error("pending event lost or changed");

endmodule : tes_event_gen
`default_nettype wire

// ---- tes_ring_sink.sv ----
`timescale 1ns/1ns
`default_nettype none

// Event ring consumer, prompt or stalling three cycles in four
module tes_ring_sink
	import tes_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic slow,
	output logic ready
);
	logic [1:0] cnt_r;

	// Free running pace count
	always_ff @(posedge clk)
		cnt_r <= rst ? 2'h0 : cnt_r + 2'h1;

	// Slow mode takes one cycle in four
	assign ready = !slow || cnt_r == 2'h3;
endmodule : tes_ring_sink

`default_nettype wire

// ---- transfer_event_short_packet_error_tb.sv ----
`timescale 1ns/1ns
`default_nettype none

`define CHK(a, b, m) \
	begin \
		samples_checked++; \
		if ((a) !== (b)) \
		begin \
			err_total++; \
			$display("wrong value at %0t: %s", $time, m); \
		end \
	end

module transfer_event_short_packet_error_tb;
	import tes_pkg::*;
	logic clk, rst, trb_valid, trb_ready, iso, parse_all_event_data_flag, rep_ok, db, ev_valid, ev_ready;
	logic sched, stall_en, slow, post, pw;
	tes_trb_t trb_in;
	tes_event_t ev_out;
	tes_endpoint_state_field_t endpoint_state_field;
	tes_event_t expq[$];
	logic [ACC_W-1:0] acc, pl;
	logic [CODE_W-1:0] pc;
	logic [ACC_W-1:0] tsum, tmov;
	logic [2*ACC_W-1:0] rs, r7;
	logic [2*ACC_W-1:0] r7q[$];
	logic [PTR_W-1:0] lastq[$];
	logic [31:0] seed = 32'h917BFA9B;
	int err_total = 0;
	int samples_checked = 0;

	tes_event_gen tes_event_gen_i (
		.REF_CLK(clk), .RESET(rst), .TRB_VALID(trb_valid), .TRB_READY(trb_ready),
		.TRB_IN(trb_in), .ISOCH(iso), .PARSE_ALL_EVENT_DATA_FLAG(parse_all_event_data_flag),
		.RESET_EP_OK(rep_ok), .DOORBELL(db), .EVENT_VALID(ev_valid),
		.EVENT_READY(ev_ready), .EVENT_OUT(ev_out), .ENDPOINT_STATE_FIELD(endpoint_state_field),
		.SCHEDULED(sched), .STALL_HANDSHAKE_EN(stall_en)
	);
	tes_ring_sink tes_ring_sink_i (.clk(clk), .rst(rst), .slow(slow), .ready(ev_ready));

	// Clock
	initial
	begin
		clk = 1'b0;
		forever #2 clk = !clk;
	end

	// Xorshift source
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	task automatic final_report();
		$display("checks %0d errors %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : final_report

	task automatic hang();
		err_total++;
		$display("wrong value at %0t: wait timed out", $time);
		final_report();
	endtask : hang

	// Expected event of one entry, queued in ring order
	task automatic predict(input tes_trb_t t);
		tes_event_t e;
		logic hit;
		e = '0;
		e.ptr = t.ptr;
		e.code = CC_SUCCESS;
		e.ed = t.kind == TRB_EVDATA;
		hit = t.completion_interrupt_flag;
		if (t.kind == TRB_LINK)
			e.len = '0;
		else if (post)
		begin
			hit = t.completion_interrupt_flag && (!e.ed || pw);
			e.code = pc;
			e.len = e.ed ? acc : pl;
			acc = (hit && e.ed) ? '0 : acc;
		end
		else if (t.stall || t.err_code != CC_NONE)
		begin
			hit = 1'b1;
			e.code = t.stall ? CC_STALL : t.err_code;
			e.len = ACC_W'(t.len - t.residue);
			acc = '0;
			{tsum, tmov} = '0;
		end
		else if (e.ed)
		begin
			e.len = acc;
			acc = t.completion_interrupt_flag ? '0 : acc;
		end
		else
		begin
			acc = acc + ACC_W'(t.len - t.residue);
			tsum = tsum + ACC_W'(t.len);
			tmov = tmov + ACC_W'(t.len - t.residue);
			if (t.short_pkt)
			begin
				hit = t.short_packet_interrupt_flag || t.completion_interrupt_flag;
				e.code = CC_SHORT;
				e.len = ACC_W'(t.residue);
				pc = CC_SHORT;
				pl = e.len;
				rs = {tsum, tmov};
			end
		end
		post = (post || t.short_pkt) && !t.last;
		acc = t.last ? '0 : acc;
		if (hit)
		begin
			expq.push_back(e);
			if (e.code == CC_SHORT && !e.ed)
				r7q.push_back(rs);
			if (t.last)
				lastq.push_back(t.ptr);
		end
		if (t.last)
			{tsum, tmov} = '0;
	endtask : predict

	// Offer one entry, flags {ioc, isp, last, short, stall}
	task automatic send(input tes_trb_kind_t k, input logic [4:0] f, input logic [7:0] ec);
		tes_trb_t t;
		int n;
		t = '0;
		t.ptr = {rnd(), rnd()};
		t.kind = k;
		{t.completion_interrupt_flag, t.short_packet_interrupt_flag, t.last, t.short_pkt, t.stall} = f;
		t.len = LEN_W'(rnd() % 1024 + 512);
		t.residue = t.short_pkt ? LEN_W'(rnd() % 511 + 1) : '0;
		t.err_code = ec;
		predict(t);
		trb_valid <= 1'b1;
		trb_in <= t;
		parse_all_event_data_flag <= pw;
		n = 0;
		do
		begin
			@(negedge clk);
			n++;
		end while (trb_ready !== 1'b1 && n < 200);
		if (n >= 200)
			hang();
		@(posedge clk);
	endtask : send

	// Wait until every expected event has left
	task automatic drain();
		int n;
		trb_valid <= 1'b0;
		n = 0;
		while ((expq.size() != 0 || ev_valid !== 1'b0) && n < 300)
		begin
			@(negedge clk);
			n++;
		end
		if (n >= 300)
			hang();
		@(posedge clk);
	endtask : drain

	task automatic pulse(input logic [1:0] p);
		{db, rep_ok} <= p;
		@(posedge clk);
		{db, rep_ok} <= 2'b00;
		@(posedge clk);
	endtask : pulse

	task automatic check_state(input tes_endpoint_state_field_t s);
		@(negedge clk);
		`CHK(endpoint_state_field, s, "state")
		`CHK(sched, s == EP_RUNNING, "schedule")
		`CHK(trb_ready, s == EP_RUNNING, "ready")
		`CHK(stall_en, 1'b0, "stall handshake")
		@(posedge clk);
	endtask : check_state

	// Compare each event as the ring takes it
	always @(negedge clk)
		if (ev_valid === 1'b1 && ev_ready === 1'b1)
		begin
			if (expq.size() == 0)
				`CHK(1'b0, 1'b1, "extra event")
			else
				`CHK(ev_out, expq.pop_front(), "event")
			// Software view: bytes received from a short report
			if (ev_out.code == CC_SHORT && !ev_out.ed && r7q.size() != 0)
			begin
				r7 = r7q.pop_front();
				`CHK(r7[2*ACC_W-1:ACC_W] - ev_out.len, r7[ACC_W-1:0], "received bytes")
			end
			// Software view: TD done only when the event points at its last entry
			if (lastq.size() != 0 && ev_out.ptr === lastq[0])
				void'(lastq.pop_front());
		end

	// Main sequence
	initial
	begin
		int n, s;
		logic [31:0] r;
		{rst, trb_valid, iso, parse_all_event_data_flag, rep_ok, db, slow, post, pw} = 9'h100;
		trb_in = '0;
		acc = '0;
		pl = '0;
		pc = CC_NONE;
		{tsum, tmov, rs, r7} = '0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		check_state(EP_STOPPED);
		pulse(2'b10);
		check_state(EP_RUNNING);
		send(TRB_NORMAL, 5'b01000, CC_NONE);
		send(TRB_NORMAL, 5'b10100, CC_NONE);
		send(TRB_NORMAL, 5'b10000, CC_NONE);
		send(TRB_NORMAL, 5'b00000, CC_NONE);
		send(TRB_LINK, 5'b10000, CC_NONE);
		send(TRB_EVDATA, 5'b10000, CC_NONE);
		send(TRB_EVDATA, 5'b10000, CC_NONE);
		send(TRB_NORMAL, 5'b10100, CC_NONE);
		send(TRB_NORMAL, 5'b01010, CC_NONE);
		send(TRB_EVDATA, 5'b10000, CC_NONE);
		pw = 1'b1;
		send(TRB_EVDATA, 5'b10000, CC_NONE);
		send(TRB_LINK, 5'b10000, CC_NONE);
		send(TRB_NORMAL, 5'b10100, CC_NONE);
		pw = 1'b0;
		drain();
		// Random TDs against a ring that is prompt or stalling, picked at random per TD
		repeat (40)
		begin
			r = rnd();
			slow <= r[0];
			n = int'(r[2:1]) + 1;
			s = int'(r[5:3]);
			for (int i = 0; i < n; i++)
				send(TRB_NORMAL, {i == n - 1, i != n - 1, i == n - 1, i == s, 1'b0}, CC_NONE);
		end
		drain();
		send(TRB_NORMAL, 5'b00000, 8'h04);
		drain();
		check_state(EP_HALTED);
		pulse(2'b01);
		check_state(EP_STOPPED);
		pulse(2'b10);
		check_state(EP_RUNNING);
		send(TRB_SETUP, 5'b00001, CC_NONE);
		drain();
		check_state(EP_HALTED);
		pulse(2'b01);
		pulse(2'b10);
		iso <= 1'b1;
		send(TRB_NORMAL, 5'b00100, 8'h04);
		send(TRB_NORMAL, 5'b10100, CC_NONE);
		drain();
		check_state(EP_RUNNING);
		`CHK(lastq.size(), 0, "TD completions")
		`CHK(r7q.size(), 0, "short reports")
		final_report();
	end
endmodule : transfer_event_short_packet_error_tb

`default_nettype wire
